/* logic/msc_top.sv */
// sideband control pins of a pluggable module, module side
//
// Notes on behaviour
// R1: selected module answers two-wire commands
// R2: deselected module never acknowledges or acts
// R3: host waits deassert time before traffic
// R4: host waits assert time after selecting
// R5: hosts may overlap waits across modules
// R6: long reset pulse restores every default
// R7: dual input active high, idles asserted
// R8: dual input means low power after reset
// R9: transmit disable selectable, refused during reset
// R10: presence line held low while inserted
// R11: interrupt line only pulls low
// R12: dual output means interrupt after reset
// R13: pull interrupt low on any flag
// R14: host reads flags to find cause
// R15: release interrupt when all flags read
// R16: receive loss selectable, refused during reset
// R17: function switch causes no idle-line glitch
// R18: reset pin synchronised, short pulses ignored
`timescale 1ns/1ps
module msc_top
    import msc_pkg::*;
(
    input  wire logic              clock_i,
    input  wire logic              rst_n_i,
    input  wire logic              link_clock_i,
    input  wire logic              module_select_n_i,
    input  wire logic              module_reset_n_i,
    input  wire logic              lp_tx_i,
    input  wire logic              rx_loss_i,
    input  wire logic [FLAG_W-1:0] flag_event_i,
    input  wire logic              tw_addr_match_i,
    input  wire logic              cmd_valid_i,
    input  wire logic [CMD_W-1:0]  cmd_code_i,
    output logic                   twi_ack_o,
    output logic                   cmd_taken_o,
    output logic                   low_power_o,
    output logic                   transmit_disable_o,
    output logic                   module_present_n_o,
    output logic                   int_rxlos_out_o,
    output logic                   int_rxlos_oe_n_o,
    output logic                   reset_busy_o,
    output logic                   input_mode_o,
    output logic                   output_mode_o,
    output logic [FLAG_W-1:0]      flags_o
);

    typedef struct packed {
        logic             ack;
        logic             taken;
        logic [CMD_N-1:0] ev;
    } msc_link_t;

    typedef struct packed {
        logic [RST_CNT_W-1:0] rst_cnt;
        logic                 busy;
        logic                 in_mode;
        logic                 out_mode;
        logic [FLAG_W-1:0]    flags;
        logic                 low_power;
        logic                 tx_dis;
        logic                 oe_n;
        logic                 present_n;
        logic                 pull;
    } msc_core_t;

    // one-hot decode of a command code
    function automatic logic [CMD_N-1:0] cmd_decode(input logic [CMD_W-1:0] code);
        logic [CMD_N-1:0] hot;
        hot = '0;
        for (int i = 0; i < CMD_N; i++) begin
            if (code == CMD_W'(i)) begin
                hot[i] = 1'b1;
            end
        end
        return hot;
    endfunction

    logic [1:0]       core_rst_pipe;
    logic [1:0]       link_rst_pipe;
    logic             core_rst_n;
    logic             link_rst_n;
    logic             sel_n_level;
    logic             reset_level;
    logic             lp_level;
    logic [CMD_N-1:0] core_ev;
    msc_link_t        ls;
    msc_link_t        next_ls;
    msc_core_t        cs;
    msc_core_t        next_cs;

    // ==========================================================
    // reset release, two flops per clock domain
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_rst_pipe <= 2'h0;
        end else begin
            core_rst_pipe <= {core_rst_pipe[0], 1'b1};
        end
    end

    always_ff @(posedge link_clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            link_rst_pipe <= 2'h0;
        end else begin
            link_rst_pipe <= {link_rst_pipe[0], 1'b1};
        end
    end

    assign core_rst_n = core_rst_pipe[1];
    assign link_rst_n = link_rst_pipe[1];

    // ==========================================================
    // pin synchronisers
    msc_sync #(
        .RESET_VAL (PIN_IDLE_LEVEL)
    ) u_sel_sync (
        .clock_i (link_clock_i),
        .rst_n_i (link_rst_n),
        .async_i (module_select_n_i),
        .level_o (sel_n_level)
    );

    msc_sync #(
        .RESET_VAL (PIN_IDLE_LEVEL)
    ) u_rst_sync (
        .clock_i (clock_i),
        .rst_n_i (core_rst_n),
        .async_i (module_reset_n_i),
        .level_o (reset_level)
    );

    msc_sync #(
        .RESET_VAL (PIN_IDLE_LEVEL)
    ) u_lp_sync (
        .clock_i (clock_i),
        .rst_n_i (core_rst_n),
        .async_i (lp_tx_i),
        .level_o (lp_level)
    );

    // ==========================================================
    // link side: acknowledge and take commands only while selected
    always_comb begin
        next_ls       = ls;
        next_ls.ack   = tw_addr_match_i & ~sel_n_level; // R1 R2
        next_ls.taken = cmd_valid_i & ~sel_n_level; // R1 R2
        next_ls.ev    = next_ls.taken ? cmd_decode(cmd_code_i) : '0;
    end

    always_ff @(posedge link_clock_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            ls <= '{1'b0, 1'b0, '0};
        end else begin
            ls <= next_ls;
        end
    end

    // command events cross into the management clock
    for (genvar g = 0; g < CMD_N; g++) begin : g_xfer
        msc_pulse_xfer u_xfer (
            .src_clock_i (link_clock_i),
            .src_rst_n_i (link_rst_n),
            .pulse_i     (ls.ev[g]),
            .dst_clock_i (clock_i),
            .dst_rst_n_i (core_rst_n),
            .pulse_o     (core_ev[g])
        );
    end

    // ==========================================================
    // core side: reset qualifier, modes, flags and pin drive
    always_comb begin
        next_cs = cs;
        // count low time of the reset pin, saturating
        if (reset_level) begin
            next_cs.rst_cnt = '0; // R18
        end else if (cs.rst_cnt != RESET_MIN_CYCLES) begin
            next_cs.rst_cnt = cs.rst_cnt + 16'h1; // R18
        end
        next_cs.busy = (next_cs.rst_cnt == RESET_MIN_CYCLES); // R6 R18
        if (next_cs.busy) begin
            next_cs.in_mode  = MODE_IN_RESET; // R6 R8 R9
            next_cs.out_mode = MODE_OUT_RESET; // R6 R12 R16
            next_cs.flags    = FLAGS_RESET; // R6
        end else begin
            if (core_ev[CMD_IN_TRANSMIT_DISABLE] && SUPPORT_TX_DISABLE) begin
                next_cs.in_mode = 1'b1; // R9
            end
            if (core_ev[CMD_IN_LOW_POWER_REQUEST]) begin
                next_cs.in_mode = 1'b0;
            end
            if (core_ev[CMD_OUT_LOS] && SUPPORT_DUAL_OUT) begin
                next_cs.out_mode = 1'b1; // R16
            end
            if (core_ev[CMD_OUT_INT]) begin
                next_cs.out_mode = 1'b0;
            end
            // a new event wins over the clear of a flag read
            next_cs.flags = (core_ev[CMD_FLAG_READ] ? FLAGS_RESET : cs.flags)
                            | flag_event_i; // R13 R15
        end
        next_cs.low_power = ~next_cs.in_mode & lp_level; // R7 R8
        next_cs.tx_dis    = next_cs.in_mode & lp_level; // R9
        // mode and level settle in one edge, so a switch cannot glitch
        if (next_cs.out_mode) begin
            next_cs.oe_n = ~rx_loss_i; // R16 R17
        end else begin
            next_cs.oe_n = ~(|next_cs.flags); // R13 R15 R17
        end
        next_cs.present_n = PRESENT_LEVEL; // R10
        next_cs.pull      = PULL_LEVEL; // R11
    end

    always_ff @(posedge clock_i or negedge core_rst_n) begin
        if (!core_rst_n) begin
            cs <= '{'0, 1'b0, MODE_IN_RESET, MODE_OUT_RESET, FLAGS_RESET,
                    PIN_IDLE_LEVEL, 1'b0, 1'b1, PRESENT_LEVEL, PULL_LEVEL};
        end else begin
            cs <= next_cs;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign twi_ack_o          = ls.ack;
    assign cmd_taken_o        = ls.taken;
    assign low_power_o        = cs.low_power;
    assign transmit_disable_o = cs.tx_dis;
    assign module_present_n_o = cs.present_n;
    assign int_rxlos_out_o    = cs.pull;
    assign int_rxlos_oe_n_o   = cs.oe_n;
    assign reset_busy_o       = cs.busy;
    assign input_mode_o       = cs.in_mode;
    assign output_mode_o      = cs.out_mode;
    assign flags_o            = cs.flags;

    // ==========================================================
    // assertions
    property p_ack_selected;
        @(posedge link_clock_i) disable iff (!link_rst_n)
        (!sel_n_level && tw_addr_match_i && cmd_valid_i) |=> (twi_ack_o && cmd_taken_o);
    endproperty
    a_ack_selected: assert property (p_ack_selected) // R1
        else $error("selected module did not answer");

    property p_silent_deselected;
        @(posedge link_clock_i) disable iff (!link_rst_n)
        sel_n_level |=> (!twi_ack_o && !cmd_taken_o && ls.ev == '0);
    endproperty
    a_silent_deselected: assert property (p_silent_deselected) // R2
        else $error("deselected module answered");

    property p_full_reset;
        @(posedge clock_i) disable iff (!core_rst_n)
        reset_busy_o |-> (!input_mode_o && !output_mode_o && flags_o == FLAGS_RESET);
    endproperty
    a_full_reset: assert property (p_full_reset) // R6
        else $error("settings not at default during reset");

    property p_short_pulse;
        @(posedge clock_i) disable iff (!core_rst_n)
        (!reset_level && cs.rst_cnt < RESET_MIN_CYCLES - 16'h1) |=> !reset_busy_o;
    endproperty
    a_short_pulse: assert property (p_short_pulse) // R18
        else $error("short reset pulse was taken");

    property p_high_clears;
        @(posedge clock_i) disable iff (!core_rst_n)
        reset_level |=> (cs.rst_cnt == '0 && !reset_busy_o);
    endproperty
    a_high_clears: assert property (p_high_clears) // R18
        else $error("reset counter not cleared");

    property p_low_power;
        @(posedge clock_i) disable iff (!core_rst_n)
        ##1 (low_power_o == (!input_mode_o && $past(lp_level)));
    endproperty
    a_low_power: assert property (p_low_power) // R7
        else $error("low power output wrong");

    property p_transmit_disable_switch;
        @(posedge clock_i) disable iff (!core_rst_n)
        (core_ev[CMD_IN_TRANSMIT_DISABLE] && !core_ev[CMD_IN_LOW_POWER_REQUEST] && reset_level)
            |=> input_mode_o;
    endproperty
    a_transmit_disable_switch: assert property (p_transmit_disable_switch) // R9
        else $error("transmit disable mode not taken");

    property p_los_switch;
        @(posedge clock_i) disable iff (!core_rst_n)
        (core_ev[CMD_OUT_LOS] && reset_busy_o && !reset_level)
            |=> !output_mode_o;
    endproperty
    a_los_switch: assert property (p_los_switch) // R16
        else $error("mode change accepted during reset");

    property p_int_low;
        @(posedge clock_i) disable iff (!core_rst_n)
        (!output_mode_o && flags_o != FLAGS_RESET) |-> !int_rxlos_oe_n_o;
    endproperty
    a_int_low: assert property (p_int_low) // R13
        else $error("interrupt not pulled low");

    property p_int_release;
        @(posedge clock_i) disable iff (!core_rst_n)
        (!output_mode_o && flags_o == FLAGS_RESET) |-> int_rxlos_oe_n_o;
    endproperty
    a_int_release: assert property (p_int_release) // R15
        else $error("interrupt held with no flags");

    property p_open_collector;
        @(posedge clock_i) disable iff (!core_rst_n)
        !int_rxlos_out_o && !module_present_n_o;
    endproperty
    a_open_collector: assert property (p_open_collector) // R10 R11
        else $error("pin driven high");

    // ==========================================================
    // scenario coverage
    c_full_reset: cover property (@(posedge clock_i) disable iff (!core_rst_n)
        $rose(reset_busy_o));
    c_ack: cover property (@(posedge link_clock_i) disable iff (!link_rst_n)
        twi_ack_o);
    c_los_mode: cover property (@(posedge clock_i) disable iff (!core_rst_n)
        $rose(output_mode_o));
    c_int_cycle: cover property (@(posedge clock_i) disable iff (!core_rst_n)
        !int_rxlos_oe_n_o ##[1:50] int_rxlos_oe_n_o);

endmodule

/* pkg/msc_pkg.sv */
// shared constants of the module sideband control block
package msc_pkg;

    // ==========================================================
    // clock and reset timing
    localparam int unsigned CLOCK_PERIOD_NS    = 20;
    localparam int unsigned RESET_MIN_PULSE_NS = 2000;
    localparam int unsigned RST_CNT_W          = 16;
    localparam logic [15:0] RESET_MIN_CYCLES   =
        16'((RESET_MIN_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    // ==========================================================
    // field widths
    localparam int unsigned FLAG_W = 4;
    localparam int unsigned CMD_W  = 3;
    localparam int unsigned CMD_N  = 5;

    // ==========================================================
    // management commands forwarded from the two-wire side
    localparam logic [2:0] CMD_IN_LOW_POWER_REQUEST = 3'h0;
    localparam logic [2:0] CMD_IN_TRANSMIT_DISABLE  = 3'h1;
    localparam logic [2:0] CMD_OUT_INT   = 3'h2;
    localparam logic [2:0] CMD_OUT_LOS   = 3'h3;
    localparam logic [2:0] CMD_FLAG_READ = 3'h4;

    // ==========================================================
    // reset values and options
    localparam logic       PIN_IDLE_LEVEL     = 1'b1;
    localparam logic       MODE_IN_RESET      = 1'b0;
    localparam logic       MODE_OUT_RESET     = 1'b0;
    localparam logic [3:0] FLAGS_RESET        = 4'h0;
    localparam logic       PRESENT_LEVEL      = 1'b0;
    localparam logic       PULL_LEVEL         = 1'b0;
    localparam logic       SUPPORT_TX_DISABLE = 1'b1;
    localparam logic       SUPPORT_DUAL_OUT   = 1'b1;

endpackage

/* logic/msc_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module msc_sync
    import msc_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clock_i,
    input  wire logic rst_n_i,
    input  wire logic async_i,
    output logic      level_o
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } msc_sync_state_t;

    msc_sync_state_t st;
    msc_sync_state_t next_st;

    // ==========================================================
    // shift chain; level moves only once stages two and three agree
    always_comb begin
        next_st       = st;
        next_st.s1    = async_i;
        next_st.s2    = st.s1;
        next_st.s3    = st.s2;
        next_st.level = (st.s2 == st.s3) ? st.s3 : st.level;
    end

    // state register
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.level;

endmodule

/* logic/msc_pulse_xfer.sv */
// toggle crossing of a one-cycle event between two clocks
`timescale 1ns/1ps
module msc_pulse_xfer
    import msc_pkg::*;
(
    input  wire logic src_clock_i,
    input  wire logic src_rst_n_i,
    input  wire logic pulse_i,
    input  wire logic dst_clock_i,
    input  wire logic dst_rst_n_i,
    output logic      pulse_o
);

    typedef struct packed {
        logic prev;
        logic pulse;
    } msc_xfer_dst_t;

    logic          tog;
    logic          tog_level;
    msc_xfer_dst_t dst;
    msc_xfer_dst_t next_dst;

    // ==========================================================
    // source side: each event flips the toggle
    always_ff @(posedge src_clock_i or negedge src_rst_n_i) begin
        if (!src_rst_n_i) begin
            tog <= 1'b0;
        end else begin
            tog <= tog ^ pulse_i;
        end
    end

    msc_sync #(
        .RESET_VAL (1'b0)
    ) u_sync (
        .clock_i (dst_clock_i),
        .rst_n_i (dst_rst_n_i),
        .async_i (tog),
        .level_o (tog_level)
    );

    // ==========================================================
    // destination side: a change of the agreed level is one event
    always_comb begin
        next_dst       = dst;
        next_dst.prev  = tog_level;
        next_dst.pulse = tog_level ^ dst.prev;
    end

    always_ff @(posedge dst_clock_i or negedge dst_rst_n_i) begin
        if (!dst_rst_n_i) begin
            dst <= '{1'b0, 1'b0};
        end else begin
            dst <= next_dst;
        end
    end

    assign pulse_o = dst.pulse;

endmodule

/* verif/msc_host_model.sv */
// host controller model: drives select and two-wire command traffic
`timescale 1ns/1ps
module msc_host_model
    import msc_pkg::*;
(
    input  wire logic             twi_ack_i,
    input  wire logic             cmd_taken_i,
    output logic                  link_clock_o,
    output logic                  module_select_n_o,
    output logic                  tw_addr_match_o,
    output logic                  cmd_valid_o,
    output logic [CMD_W-1:0]      cmd_code_o
);
    logic run = 1'b0;
    logic got_ack = 1'b0;
    logic got_taken = 1'b0;
    event done;

    // ==========================================================
    // link clock runs only inside frames, parked low between them
    initial begin
        link_clock_o = 1'b0;
        module_select_n_o = 1'b1;
        tw_addr_match_o = 1'b0;
        cmd_valid_o = 1'b0;
        cmd_code_o = 3'h7;
    end
    always begin
        #16;
        link_clock_o = run ? ~link_clock_o : 1'b0;
    end

    // ==========================================================
    // one frame: select, settle wait, one command, sample the answer
    task automatic frame(input logic sel_n, input logic [CMD_W-1:0] code);
        module_select_n_o = sel_n; // clock parked, no edge to race
        run = 1'b1;
        repeat (8) @(posedge link_clock_o);
        tw_addr_match_o <= 1'b1;
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        @(posedge link_clock_o);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code; // released code bus shows no stale value
        // answer launched at the edge above, read while it stands
        @(negedge link_clock_o);
        got_ack = twi_ack_i;
        got_taken = cmd_taken_i;
        @(posedge link_clock_o);
        tw_addr_match_o <= 1'b0;
        ->done;
        repeat (4) @(posedge link_clock_o);
        run = 1'b0;
    endtask
endmodule

/* verif/module_sideband_control_test.sv */
// self-checking bench for the module sideband control block
`timescale 1ns/1ps
module module_sideband_control_test
    import msc_pkg::*;
;
    logic              clock_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic              module_reset_n_i = 1'b1;
    logic              lp_tx_i = 1'b1;
    logic              rx_loss_i = 1'b0;
    logic [FLAG_W-1:0] flag_event_i = '0;
    logic              link_clock, sel_n, match, cmd_valid, twi_ack, taken;
    logic              low_power, tx_dis, present_n, line_out, oe_n, busy;
    logic              in_mode, out_mode, exp_in, exp_out, quiet = 1'b0;
    logic [CMD_W-1:0]  code;
    logic [FLAG_W-1:0] flags, ev, ev2;
    logic [2:0]        note;
    logic [2:0]        exp_q[$];
    logic [CMD_W-1:0]  order[4] = '{CMD_IN_TRANSMIT_DISABLE, CMD_OUT_LOS, CMD_IN_LOW_POWER_REQUEST, CMD_OUT_INT};
    int                miscompares = 0, checks_done = 0, cycles = 0;
    integer            seed = 32'h03ed;

    always #10 clock_i = ~clock_i;

    msc_top u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .link_clock_i(link_clock),
        .module_select_n_i(sel_n), .module_reset_n_i(module_reset_n_i),
        .lp_tx_i(lp_tx_i), .rx_loss_i(rx_loss_i), .flag_event_i(flag_event_i),
        .tw_addr_match_i(match), .cmd_valid_i(cmd_valid), .cmd_code_i(code),
        .twi_ack_o(twi_ack), .cmd_taken_o(taken), .low_power_o(low_power),
        .transmit_disable_o(tx_dis), .module_present_n_o(present_n),
        .int_rxlos_out_o(line_out), .int_rxlos_oe_n_o(oe_n), .reset_busy_o(busy),
        .input_mode_o(in_mode), .output_mode_o(out_mode), .flags_o(flags)
    );
    msc_host_model u_host (
        .twi_ack_i(twi_ack), .cmd_taken_i(taken), .link_clock_o(link_clock),
        .module_select_n_o(sel_n), .tw_addr_match_o(match),
        .cmd_valid_o(cmd_valid), .cmd_code_o(code)
    );

    // ==========================================================
    // comparison, closing report and helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    // note the expected answer, run the frame, let the mode cross over
    task automatic send(input logic s, input logic [CMD_W-1:0] cc, input logic care);
        exp_q.push_back({care, ~s, ~s});
        u_host.frame(s, cc);
        settle(20);
    endtask
    task automatic raise(input logic [FLAG_W-1:0] v);
        @(posedge clock_i);
        flag_event_i <= v;
        @(posedge clock_i);
        flag_event_i <= '0;
        settle(1);
    endtask

    // ==========================================================
    // answer monitor: each frame result is matched to the oldest note
    always @(u_host.done) begin
        if (exp_q.size() == 0) begin
            check(8'h00, 8'hff);
        end else begin
            note = exp_q.pop_front();
            check(u_host.got_ack, note[1]);
            if (note[2]) check(u_host.got_taken, note[0]);
        end
    end

    // per-cycle line watch and hang limit, away from the launch edge
    always @(negedge clock_i) begin
        cycles <= cycles + 1;
        if (oe_n === 1'b0 && line_out !== 1'b0) check(line_out, 1'b0);
        if (quiet && oe_n !== 1'b1) check(oe_n, 1'b1);
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        rst_n_i <= 1'b1;
        settle(4);
        check({low_power, tx_dis, present_n, line_out, oe_n, busy, in_mode, out_mode},
              8'h88);
        check(flags, 8'h00);
        $display("test defaults done");
        // every mode command, line must stay quiet with no flags
        quiet = 1'b1;
        exp_in = 1'b0;
        exp_out = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock_i);
            lp_tx_i <= 1'($random(seed));
            send(1'b0, order[i], 1'b1);
            if (order[i] < CMD_OUT_INT) exp_in = order[i][0];
            else exp_out = order[i][0];
            check({in_mode, out_mode}, {exp_in, exp_out});
            check({low_power, tx_dis}, {lp_tx_i & ~exp_in, lp_tx_i & exp_in});
        end
        for (int k = 5; k < 8; k++) send(1'b0, 3'(k), 1'b1);
        send(1'b1, CMD_IN_TRANSMIT_DISABLE, 1'b1);
        check({in_mode, out_mode}, 8'h00);
        quiet = 1'b0;
        $display("test mode commands done");
        // flags pull the line, only a selected read releases it
        ev = 4'($random(seed)) | 4'h1;
        raise(ev);
        check({flags, oe_n}, {ev, 1'b0});
        ev2 = 4'($random(seed));
        raise(ev2);
        send(1'b1, CMD_FLAG_READ, 1'b1);
        check({flags, oe_n}, {ev | ev2, 1'b0});
        send(1'b0, CMD_FLAG_READ, 1'b1);
        check({flags, oe_n}, 8'h01);
        // receive loss function on the shared line
        send(1'b0, CMD_OUT_LOS, 1'b1);
        @(posedge clock_i);
        rx_loss_i <= 1'b1;
        settle(3);
        check(oe_n, 1'b0);
        @(posedge clock_i);
        rx_loss_i <= 1'b0;
        settle(3);
        check(oe_n, 1'b1);
        send(1'b0, CMD_IN_TRANSMIT_DISABLE, 1'b1);
        raise(4'h2);
        $display("test flags done");
        // reset pin: short pulse ignored, long one restores defaults
        @(posedge clock_i);
        module_reset_n_i <= 1'b0;
        repeat (RESET_MIN_CYCLES - 5) @(posedge clock_i);
        module_reset_n_i <= 1'b1;
        settle(10);
        check({busy, in_mode, out_mode, flags}, {3'b011, 4'h2});
        @(posedge clock_i);
        module_reset_n_i <= 1'b0;
        settle(RESET_MIN_CYCLES + 10);
        check(busy, 1'b1);
        send(1'b0, CMD_IN_TRANSMIT_DISABLE, 1'b1);
        send(1'b0, CMD_OUT_LOS, 1'b1);
        check({in_mode, out_mode, flags, oe_n}, 8'h01);
        @(posedge clock_i);
        module_reset_n_i <= 1'b1;
        settle(10);
        check({busy, in_mode, out_mode, low_power, tx_dis}, {3'b000, lp_tx_i, 1'b0});
        check(8'(exp_q.size()), 8'h00);
        $display("test reset pin done");
        end_sim();
    end
endmodule
